//--- hw/lap_port_select.sv
// Link aggregation: source mapping, hash, weight lookup, egress mask
//
// Functional notes
// - Source port maps to its aggregate number
// - Destination aggregate looks up its member mask
// - Selected-field hash indexes the weight table
// - No weight port for aggregate drops packet
// - Key order DA, SA, VLAN, TOS, L4, IPs, port
// - Deselected key fields contribute zeros
// - L4 flag gates three fields, IP both
// - XOR 53 byte slices from key LSB
// - Independent select flags for each field group except source port
`timescale 1ns/10ps
`include "lap_defines.svh"

module lap_port_select #(
  parameter int NUM_PORTS    = `LAP_NUM_PORTS,
  parameter int PORT_W       = `LAP_PORT_W,
  parameter int WEIGHT_DEPTH = `LAP_WEIGHT_DEPTH
) (
  // Clock and reset
  input  wire logic                  clock_in,
  input  wire logic                  arst_n_in,
  // Control flags
  input  wire lap_pkg::lap_ctrl_t    aggregation_control_in,
  // Source-to-aggregate table write
  input  wire logic                  sp_wr_in,
  input  wire logic [PORT_W-1:0]     sp_wr_addr_in,
  input  wire logic [PORT_W-1:0]     sp_wr_data_in,
  // Aggregate-to-physical table write
  input  wire logic                  phy_wr_in,
  input  wire logic [PORT_W-1:0]     phy_wr_addr_in,
  input  wire logic [NUM_PORTS-1:0]  phy_wr_data_in,
  // Weight table write
  input  wire logic                  wt_wr_in,
  input  wire logic [7:0]            wt_wr_addr_in,
  input  wire logic [NUM_PORTS-1:0]  wt_wr_data_in,
  // Packet request from ingress pipeline
  input  wire logic                  pkt_valid_in,
  input  wire lap_pkg::lap_hdr_t     pkt_hdr_in,
  input  wire logic [PORT_W-1:0]     dst_aggregate_in,
  // Source aggregate answer, same cycle as request
  output logic [PORT_W-1:0]          src_aggregate_out,
  // Egress decision, one cycle after request
  output logic                       res_valid_out,
  output logic [NUM_PORTS-1:0]       egress_mask_out,
  output logic                       drop_out,
  output logic [7:0]                 hash_out
);

  // ---------------------------------------------------------------
  // Functions
  // ---------------------------------------------------------------
  function automatic logic [`LAP_KEY_W-1:0] build_key(
    input lap_pkg::lap_hdr_t h,
    input lap_pkg::lap_ctrl_t c
  );
    logic l4;
    logic ip;
    l4 = c.hash_select_transport_fields;
    ip = c.hash_select_ip_addresses;
    build_key = {
      c.hash_select_destination_mac ? h.dst_mac : 48'h0,
      c.hash_select_source_mac      ? h.src_mac : 48'h0,
      c.hash_select_vlan_id         ? h.vlan_id : 12'h0,
      c.hash_select_service_type    ? h.service_type : 8'h0,
      l4 ? h.l4_src_port : 16'h0,
      l4 ? h.l4_dst_port : 16'h0,
      l4 ? h.ip_proto    : 8'h0,
      ip ? h.src_ip : 128'h0,
      ip ? h.dst_ip : 128'h0,
      h.src_port};
  endfunction : build_key

  function automatic logic [7:0] fold_hash(
    input logic [`LAP_KEY_W-1:0] key
  );
    logic [`LAP_FOLD_W-1:0] wide;
    wide = {6'h0, key};
    fold_hash = 8'h00;
    for (int j = 0; j < `LAP_HASH_SLICES; j++)
    begin
      fold_hash = fold_hash ^ wide[j*8 +: 8];
    end
  endfunction : fold_hash

  // ---------------------------------------------------------------
  // Tables
  // ---------------------------------------------------------------
  logic [PORT_W-1:0]    sp_tab_q  [NUM_PORTS];
  logic [NUM_PORTS-1:0] phy_tab_q [NUM_PORTS];
  logic [NUM_PORTS-1:0] wt_tab_q  [WEIGHT_DEPTH];

  // Reset gives the identity mapping so traffic flows before setup
  always_ff @(posedge clock_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      for (int i = 0; i < NUM_PORTS; i++)
      begin
        sp_tab_q[i]  <= PORT_W'(i);
        phy_tab_q[i] <= NUM_PORTS'(1) << i;
      end
    end
    else
    begin
      if (sp_wr_in && sp_wr_addr_in < NUM_PORTS)
        sp_tab_q[sp_wr_addr_in] <= sp_wr_data_in;
      if (phy_wr_in && phy_wr_addr_in < NUM_PORTS)
        phy_tab_q[phy_wr_addr_in] <= phy_wr_data_in;
    end
  end

  // All-ones weight entries let each identity aggregate reach its port
  always_ff @(posedge clock_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      for (int i = 0; i < WEIGHT_DEPTH; i++)
        wt_tab_q[i] <= {NUM_PORTS{1'b1}};
    end
    else if (wt_wr_in)
    begin
      wt_tab_q[wt_wr_addr_in] <= wt_wr_data_in;
    end
  end

  // ---------------------------------------------------------------
  // Lookup path
  // ---------------------------------------------------------------
  logic                 en;
  logic [7:0]           hash_d;
  logic [NUM_PORTS-1:0] member_d;
  logic [NUM_PORTS-1:0] mask_d;
  logic [NUM_PORTS-1:0] weight_d;
  logic [NUM_PORTS-1:0] dst_onehot;

  assign en         = aggregation_control_in.enable;
  assign dst_onehot = NUM_PORTS'(1) << dst_aggregate_in;
  assign hash_d     = fold_hash(build_key(pkt_hdr_in,
                                          aggregation_control_in));
  // Out-of-range numbers read as empty rather than aliasing
  assign member_d   = (dst_aggregate_in < NUM_PORTS) ?
                      phy_tab_q[dst_aggregate_in] : '0;
  // Disabled: plain port numbers pass straight through
  assign weight_d   = wt_tab_q[hash_d];
  assign mask_d     = en ? (member_d & weight_d)
                         : dst_onehot;

  always_comb
  begin
    src_aggregate_out = pkt_hdr_in.src_port;
    if (en && pkt_hdr_in.src_port < NUM_PORTS)
      src_aggregate_out = sp_tab_q[pkt_hdr_in.src_port];
  end

  // ---------------------------------------------------------------
  // Result registers
  // ---------------------------------------------------------------
  always_ff @(posedge clock_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
      res_valid_out <= 1'b0;
    else
      res_valid_out <= pkt_valid_in;
  end

  always_ff @(posedge clock_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      egress_mask_out <= '0;
      drop_out        <= 1'b0;
      hash_out        <= 8'h00;
    end
    else if (pkt_valid_in)
    begin
      egress_mask_out <= mask_d;
      drop_out        <= (mask_d == '0);
      hash_out        <= hash_d;
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!arst_n_in);

  chk_result_timing: assert property (
    pkt_valid_in |=> res_valid_out)
    else $error("result valid missing one cycle after request");
  chk_no_spurious: assert property (
    !pkt_valid_in |=> !res_valid_out)
    else $error("result valid without request");
  chk_drop_empty: assert property (
    res_valid_out |-> (drop_out == (egress_mask_out == '0)))
    else $error("drop flag disagrees with empty mask");
  chk_mask_members: assert property (
    pkt_valid_in && en |=> (egress_mask_out & ~$past(member_d)) == '0)
    else $error("egress mask outside aggregate members");
  chk_mask_weight: assert property (
    pkt_valid_in && en |=>
      egress_mask_out == ($past(member_d) & $past(weight_d)))
    else $error("egress mask not members and weight");
  chk_hash_value: assert property (
    pkt_valid_in |=> hash_out == $past(hash_d))
    else $error("hash not captured with request");
  chk_zero_key_hash: assert property (
    pkt_valid_in && aggregation_control_in[6:1] == 6'h00
      |-> hash_d == {2'b00, pkt_hdr_in.src_port})
    else $error("deselected fields leaked into hash");
  chk_src_map: assert property (
    en && pkt_hdr_in.src_port < NUM_PORTS
      |-> src_aggregate_out == sp_tab_q[pkt_hdr_in.src_port])
    else $error("source aggregate not from table");
  chk_bypass: assert property (
    pkt_valid_in && !en |=> egress_mask_out == $past(dst_onehot))
    else $error("disabled path not pass-through");

  cov_drop:    cover property (res_valid_out && drop_out);
  cov_forward: cover property (res_valid_out && !drop_out && en);
  cov_back2back: cover property (pkt_valid_in [*2]);
  cov_bypass:  cover property (pkt_valid_in && !en);

endmodule : lap_port_select

//--- include/lap_defines.svh
// Constants for the link aggregation port select stage
`ifndef LAP_DEFINES_SVH
`define LAP_DEFINES_SVH
`define LAP_NUM_PORTS     53
`define LAP_PORT_W        6
`define LAP_HASH_W        8
`define LAP_HASH_SLICES   53
`define LAP_KEY_W         418
`define LAP_FOLD_W        424
`define LAP_WEIGHT_DEPTH  256
`endif

//--- include/lap_pkg.sv
// Types shared by the link aggregation port select stage
package lap_pkg;
  typedef struct packed {
    logic [47:0]  dst_mac;
    logic [47:0]  src_mac;
    logic [11:0]  vlan_id;
    logic [7:0]   service_type;
    logic [15:0]  l4_src_port;
    logic [15:0]  l4_dst_port;
    logic [7:0]   ip_proto;
    logic [127:0] src_ip;
    logic [127:0] dst_ip;
    logic [5:0]   src_port;
  } lap_hdr_t;

  typedef struct packed {
    logic hash_select_destination_mac;
    logic hash_select_source_mac;
    logic hash_select_vlan_id;
    logic hash_select_service_type;
    logic hash_select_transport_fields;
    logic hash_select_ip_addresses;
    logic enable;
  } lap_ctrl_t;
endpackage : lap_pkg

//--- tb/lap_pipe_model.sv
// Ingress pipeline model feeding parsed headers to the aggregation stage
`timescale 1ns/10ps
module lap_pipe_model (
  // Clock and command
  input  wire logic              clock_in,
  input  wire logic              send_in,
  input  wire lap_pkg::lap_hdr_t hdr_in,
  input  wire logic [5:0]        dst_in,
  // Toward the stage
  output logic                   pkt_valid_out = 1'b0,
  output lap_pkg::lap_hdr_t      pkt_hdr_out = '0,
  output logic [5:0]             dst_aggregate_out = 6'h00
);
  // Between requests the fields flip so stale values never look valid
  always @(posedge clock_in)
  begin
    pkt_valid_out     <= send_in;
    pkt_hdr_out       <= send_in ? hdr_in : ~pkt_hdr_out;
    dst_aggregate_out <= send_in ? dst_in : ~dst_aggregate_out;
  end
endmodule : lap_pipe_model

//--- tb/lap_port_select_test.sv
// Self-checking bench for the link aggregation port select stage
`timescale 1ns/10ps
module lap_port_select_test;
  logic clock_in = 1'b0, arst_n_in = 1'b0, send = 1'b0;
  logic sp_wr = 1'b0, phy_wr = 1'b0, wt_wr = 1'b0, pv, res_v, drop;
  logic [5:0] sp_a = 6'h00, sp_d = 6'h00, phy_a = 6'h00, dst = 6'h00;
  logic [5:0] pd, src_agg, got_agg;
  logic [7:0] wt_a = 8'h00, hash, h;
  logic [52:0] phy_d = '0, wt_d = '0, mask;
  logic [431:0] pat = {12{36'h9E3_7A5C_1D}};
  lap_pkg::lap_ctrl_t ctrl = '0, c;
  lap_pkg::lap_hdr_t hd = '0, ph;
  int err_total = 0, n_tests = 0;
  always #20 clock_in = ~clock_in;
  lap_pipe_model lap_pipe_model_i (.clock_in(clock_in), .send_in(send),
    .hdr_in(hd), .dst_in(dst), .pkt_valid_out(pv), .pkt_hdr_out(ph),
    .dst_aggregate_out(pd));
  lap_port_select lap_port_select_i (.clock_in(clock_in),
    .arst_n_in(arst_n_in), .aggregation_control_in(ctrl),
    .sp_wr_in(sp_wr), .sp_wr_addr_in(sp_a), .sp_wr_data_in(sp_d),
    .phy_wr_in(phy_wr), .phy_wr_addr_in(phy_a), .phy_wr_data_in(phy_d),
    .wt_wr_in(wt_wr), .wt_wr_addr_in(wt_a), .wt_wr_data_in(wt_d),
    .pkt_valid_in(pv), .pkt_hdr_in(ph), .dst_aggregate_in(pd),
    .src_aggregate_out(src_agg), .res_valid_out(res_v),
    .egress_mask_out(mask), .drop_out(drop), .hash_out(hash));
  task automatic check(input string nm, input logic [63:0] seen,
                       input logic [63:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      $display("MISMATCH %s exp %h seen %h", nm, exp, seen);
      err_total++;
    end
  endtask : check
  function automatic logic [7:0] exp_hash(lap_pkg::lap_hdr_t k,
                                          lap_pkg::lap_ctrl_t f);
    logic [423:0] w;
    logic [7:0]   x;
    if (!f.hash_select_destination_mac) k.dst_mac = '0;
    if (!f.hash_select_source_mac) k.src_mac = '0;
    if (!f.hash_select_vlan_id) k.vlan_id = '0;
    if (!f.hash_select_service_type) k.service_type = '0;
    if (!f.hash_select_transport_fields) {k.l4_src_port, k.l4_dst_port,
      k.ip_proto} = '0;
    if (!f.hash_select_ip_addresses) {k.src_ip, k.dst_ip} = '0;
    w = {6'h00, k};
    x = 8'h00;
    for (int j = 0; j < 53; j++) x ^= w[j*8 +: 8];
    return x;
  endfunction : exp_hash
  task automatic cfg(input logic [5:0] sa, sd, pa, input logic [52:0] pm,
                     input logic [7:0] wa, input logic [52:0] wm);
    @(negedge clock_in);
    {sp_wr, sp_a, sp_d, phy_wr, phy_a, phy_d} = {1'b1, sa, sd, 1'b1, pa, pm};
    {wt_wr, wt_a, wt_d} = {1'b1, wa, wm};
    @(negedge clock_in);
    {sp_wr, phy_wr, wt_wr} = 3'h0;
  endtask : cfg
  task automatic request(input logic [5:0] d);
    @(negedge clock_in);
    send = 1'b1;
    dst = d;
    @(negedge clock_in);
    send = 1'b0;
    got_agg = src_agg;
    for (int i = 0; i < 4 && res_v !== 1'b1; i++) @(negedge clock_in);
    check("res_valid", res_v, 1);
    @(negedge clock_in);
    check("res_pulse", res_v, 0);
  endtask : request
  // ----------------------------------------------------------------
  // Key field selection: no group, each flag group alone, then all groups
  // ----------------------------------------------------------------
  task automatic t_hash_fields();
    for (int i = 0; i < 8; i++)
    begin
      c = (i == 7) ? 7'h7E : (7'h01 << i) & 7'h7E;
      ctrl = c;
      request(6'h04);
      check("hash", hash, exp_hash(hd, c));
      check("mask_off", mask, 53'h1 << 4);
      check("src_pass", got_agg, 6'h05);
    end
  endtask : t_hash_fields
  // ----------------------------------------------------------------
  // Bundled aggregate, weight hit and weight miss
  // ----------------------------------------------------------------
  task automatic t_aggregate();
    c = 7'h7F;
    h = exp_hash(hd, c);
    // Port 5 joins aggregate 2; every entry keeps one member of each
    for (int a = 0; a < 256; a++)
      cfg(6'h05, 6'h02, 6'h05, 53'h0, a[7:0],
          (a == h) ? ~53'h4 : ~53'h20);
    cfg(6'h05, 6'h02, 6'h02, 53'h24, h, ~53'h4);
    ctrl = c;
    request(6'h02);
    check("src_agg", got_agg, 6'h02);
    check("hash_en", hash, h);
    check("mask", mask, 53'h20);
    check("drop", drop, 0);
    request(6'h07);
    check("mask_ident", mask, 53'h80);
    // Entry without any member of aggregate 2 must drop
    cfg(6'h05, 6'h02, 6'h02, 53'h24, h, 53'h80);
    request(6'h02);
    check("mask_miss", mask, 53'h0);
    check("drop_miss", drop, 1);
  endtask : t_aggregate
  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : end_sim
  initial
  begin
    hd = pat[417:0];
    hd.src_port = 6'h05;
    repeat (6) @(negedge clock_in);
    arst_n_in = 1'b1;
    check("rst_mask", mask, 53'h0);
    check("rst_hash", hash, 8'h00);
    t_hash_fields();
    t_aggregate();
    end_sim();
  end
  initial
  begin
    #200us;
    err_total++;
    end_sim();
  end
endmodule : lap_port_select_test
